//--- src/lscpc_defs.svh
// Purpose: offsets, field positions, encodings and reset values of the
//          second-channel flat-panel power control block
// Assumes: one 32-bit register, word addressed over Avalon-MM
// Notes:   register figures live here; lscpc_top still slices cfg_l and readdata by number
`ifndef LSCPC_DEFS_SVH
`define LSCPC_DEFS_SVH

// -----------------------------------------------------------------------
// register map
// -----------------------------------------------------------------------
`define LSCPC_CTRL_IDX 4'h0

// -----------------------------------------------------------------------
// field positions inside flat_panel_port_control
// -----------------------------------------------------------------------
`define LSCPC_EIGHTH_LSB 6
`define LSCPC_CLK_LSB 4
`define LSCPC_DATA_LSB 2
`define LSCPC_PRESENT_BIT 1

// -----------------------------------------------------------------------
// power field encodings (2'h2 is reserved)
// -----------------------------------------------------------------------
`define LSCPC_FLD_DOWN 2'h0
`define LSCPC_FLD_ZERO 2'h1
`define LSCPC_FLD_ACTIVE 2'h3

// -----------------------------------------------------------------------
// reset values and timing counts
// -----------------------------------------------------------------------
`define LSCPC_FLD_RESET 2'h0
`define LSCPC_PRES_FILL_CYCLES 2'h2

`endif

//--- src/lscpc_pkg.sv
// Purpose: types shared by the second-channel power control block
// Assumes: constants come from lscpc_defs.svh
// Notes:   levels are one-hot so a stuck or double bit is easy to spot
package lscpc_pkg;

  // allowed activity on one group of pairs
  typedef enum logic [2:0] {
    LSCPC_LVL_OFF  = 3'b001,
    LSCPC_LVL_ZERO = 3'b010,
    LSCPC_LVL_ACT  = 3'b100
  } lscpc_level_t;

  // presence capture sequence
  typedef enum logic [1:0] {
    LSCPC_PS_FILL = 2'b01,
    LSCPC_PS_HOLD = 2'b10
  } lscpc_pres_state_t;

endpackage

//--- src/lscpc_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: input changes slowly compared with the destination clock
// Notes:   no reset and no enable, so it keeps tracking in every state;
//          first stage feeds only the second stage
module lscpc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // metastable stage, read by the second stage only
  logic [WIDTH-1:0] meta;

  // two-stage capture
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end

endmodule

//--- src/lscpc_top.sv
// Purpose: second-channel power limits for a dual-channel flat-panel port
// Assumes: Avalon-MM slave on ref_clk, pair drivers on link_clk
// Notes:   line states are registered in the link domain
//
// Functional notes
// - clock field: down, forced zero, running
// - clock limited by second-channel data field
// - fields only cap activity, sequencer wins
// - data field: down, zero data, active
// - clock pair controllable apart from data
// - read-only presence flag from boot level
// - presence valid whether port enabled or not
// - sequencer power-down forces all lines down
// - eighth pair limited by both fields
`include "lscpc_defs.svh"

module lscpc_top #(
  parameter int ADDR_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic link_clk,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic seq_power_down,
  input wire logic display_serial_bus_data,
  output lscpc_pkg::lscpc_level_t second_clock_pair,
  output lscpc_pkg::lscpc_level_t second_channel_data_pairs,
  output lscpc_pkg::lscpc_level_t second_eighth_bit_pair
);

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------

  // field code to level; reserved code falls back to powered down
  function automatic lscpc_pkg::lscpc_level_t lscpc_decode(
    input logic [1:0] f
  );
    lscpc_pkg::lscpc_level_t l;
    case (f)
      `LSCPC_FLD_ZERO: l = lscpc_pkg::LSCPC_LVL_ZERO;
      `LSCPC_FLD_ACTIVE: l = lscpc_pkg::LSCPC_LVL_ACT;
      default: l = lscpc_pkg::LSCPC_LVL_OFF;
    endcase
    return l;
  endfunction

  // lower of two levels, so each field acts as a ceiling
  function automatic lscpc_pkg::lscpc_level_t lscpc_min(
    input lscpc_pkg::lscpc_level_t a,
    input lscpc_pkg::lscpc_level_t b
  );
    lscpc_pkg::lscpc_level_t l;
    if (a == lscpc_pkg::LSCPC_LVL_OFF || b == lscpc_pkg::LSCPC_LVL_OFF) begin
      l = lscpc_pkg::LSCPC_LVL_OFF;
    end else if (a == lscpc_pkg::LSCPC_LVL_ZERO ||
                 b == lscpc_pkg::LSCPC_LVL_ZERO) begin
      l = lscpc_pkg::LSCPC_LVL_ZERO;
    end else begin
      l = lscpc_pkg::LSCPC_LVL_ACT;
    end
    return l;
  endfunction

  // ---------------------------------------------------------------------
  // ref_clk domain: register file
  // ---------------------------------------------------------------------
  logic [1:0] eighth_bit_pair_power_field; // bits 7:6
  logic [1:0] second_clock_power_field; // bits 5:4
  logic [1:0] second_channel_data_power_field; // bits 3:2
  logic presence; // bit 1, captured once
  logic hit; // address decodes to the control word
  logic [31:0] rd_value; // word returned on a read
  logic bus_done; // edge at which the master sees the answer

  assign hit = (address == ADDR_W'(`LSCPC_CTRL_IDX));
  assign bus_done = (read || write) && !waitrequest;

  // read mux; unmapped words and reserved bits read zero
  always_comb begin
    rd_value = 32'h0;
    if (hit) begin
      rd_value[`LSCPC_EIGHTH_LSB +: 2] = eighth_bit_pair_power_field;
      rd_value[`LSCPC_CLK_LSB +: 2] = second_clock_power_field;
      rd_value[`LSCPC_DATA_LSB +: 2] = second_channel_data_power_field;
      rd_value[`LSCPC_PRESENT_BIT] = presence;
      rd_value[0] = 1'b0;
    end
  end

  // one wait cycle per access; answer drops waitrequest for one cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else if (clk_en) begin
      if ((read || write) && waitrequest) begin
        // answer now, data stands until the next answer
        waitrequest <= 1'b0;
        readdata <= read ? rd_value : 32'h0;
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  // field writes land on the edge where waitrequest is seen low;
  // presence and reserved bits have no write path
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eighth_bit_pair_power_field <= `LSCPC_FLD_RESET;
      second_clock_power_field <= `LSCPC_FLD_RESET;
      second_channel_data_power_field <= `LSCPC_FLD_RESET;
    end else if (clk_en && bus_done && write && hit && byteenable[0]) begin
      eighth_bit_pair_power_field <= writedata[`LSCPC_EIGHTH_LSB +: 2];
      // clock field written together with the other fields under byte lane 0
      second_clock_power_field <= writedata[`LSCPC_CLK_LSB +: 2];
      // software picks 00, 01 or 11 here
      second_channel_data_power_field <= writedata[`LSCPC_DATA_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------------
  // ref_clk domain: presence capture
  // ---------------------------------------------------------------------
  logic pin_s; // synchronised display serial bus data line
  lscpc_pkg::lscpc_pres_state_t ps_state; // capture sequence state
  lscpc_pkg::lscpc_pres_state_t next_ps_state;
  logic [1:0] fill_cnt; // cycles since reset release

  lscpc_sync #(.WIDTH(1)) u_pin_sync (
    .clk(ref_clk),
    .d(display_serial_bus_data),
    .q(pin_s)
  );

  // wait for the synchroniser to carry the pin, then hold forever
  always_comb begin
    next_ps_state = ps_state;
    case (ps_state)
      lscpc_pkg::LSCPC_PS_FILL: begin
        if (fill_cnt == `LSCPC_PRES_FILL_CYCLES) begin
          next_ps_state = lscpc_pkg::LSCPC_PS_HOLD;
        end
      end
      lscpc_pkg::LSCPC_PS_HOLD: next_ps_state = lscpc_pkg::LSCPC_PS_HOLD;
      default: next_ps_state = lscpc_pkg::LSCPC_PS_FILL;
    endcase
  end

  // state and fill counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ps_state <= lscpc_pkg::LSCPC_PS_FILL;
      fill_cnt <= 2'h0;
    end else if (clk_en) begin
      ps_state <= next_ps_state;
      if (ps_state == lscpc_pkg::LSCPC_PS_FILL) begin
        fill_cnt <= fill_cnt + 2'h1;
      end
    end
  end

  // no port enable gates the capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      presence <= 1'b0;
    end else if (clk_en && ps_state == lscpc_pkg::LSCPC_PS_FILL &&
                 fill_cnt == `LSCPC_PRES_FILL_CYCLES) begin
      presence <= pin_s;
    end
  end

  // ---------------------------------------------------------------------
  // crossing: field word handed to link_clk by toggle handshake
  // ---------------------------------------------------------------------
  logic [5:0] cfg_live; // current fields in ref domain
  logic [5:0] xfer_word; // frozen while a transfer is pending
  logic xfer_req; // toggles once per transfer
  logic ack_s; // link acknowledge brought back
  logic xfer_seen; // link side copy of the last toggle

  assign cfg_live = {eighth_bit_pair_power_field, second_clock_power_field,
                     second_channel_data_power_field};

  lscpc_sync #(.WIDTH(1)) u_ack_sync (
    .clk(ref_clk),
    .d(xfer_seen),
    .q(ack_s)
  );

  // launch a new word only once the previous one was taken, so the
  // link side never samples a word that is still moving
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      xfer_word <= {`LSCPC_FLD_RESET, `LSCPC_FLD_RESET, `LSCPC_FLD_RESET};
      xfer_req <= 1'b0;
    end else if (clk_en && xfer_req == ack_s && xfer_word != cfg_live) begin
      xfer_word <= cfg_live;
      xfer_req <= ~xfer_req;
    end
  end

  // ---------------------------------------------------------------------
  // link_clk domain
  // ---------------------------------------------------------------------
  logic link_rst_n; // reset carried into the link domain
  logic link_ce; // clock enable carried into the link domain
  logic pd_s; // sequencer power-down, synchronised
  logic req_s; // transfer toggle, synchronised
  logic [5:0] cfg_l; // fields as seen by the line logic
  lscpc_pkg::lscpc_level_t next_clk_lvl;
  lscpc_pkg::lscpc_level_t next_data_lvl;
  lscpc_pkg::lscpc_level_t next_eighth_lvl;

  lscpc_sync #(.WIDTH(4)) u_link_sync (
    .clk(link_clk),
    .d({rst_n, clk_en, seq_power_down, xfer_req}),
    .q({link_rst_n, link_ce, pd_s, req_s})
  );

  // take the word on a new toggle and hand the toggle back
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      cfg_l <= {`LSCPC_FLD_RESET, `LSCPC_FLD_RESET, `LSCPC_FLD_RESET};
      xfer_seen <= 1'b0;
    end else if (link_ce && req_s != xfer_seen) begin
      cfg_l <= xfer_word;
      xfer_seen <= req_s;
    end
  end

  // line levels from the fields
  always_comb begin
    next_data_lvl = lscpc_decode(cfg_l[1:0]);
    // clock capped by the data field
    next_clk_lvl = lscpc_min(next_data_lvl, lscpc_decode(cfg_l[3:2]));
    // eighth pair capped by both fields
    next_eighth_lvl = lscpc_min(next_data_lvl, lscpc_decode(cfg_l[5:4]));
    // fields never raise above the sequencer
    if (pd_s) begin
      next_data_lvl = lscpc_pkg::LSCPC_LVL_OFF;
      next_clk_lvl = lscpc_pkg::LSCPC_LVL_OFF;
      next_eighth_lvl = lscpc_pkg::LSCPC_LVL_OFF;
    end
  end

  // registered line levels; safe powered-down value out of reset
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      second_clock_pair <= lscpc_pkg::LSCPC_LVL_OFF;
      second_channel_data_pairs <= lscpc_pkg::LSCPC_LVL_OFF;
      second_eighth_bit_pair <= lscpc_pkg::LSCPC_LVL_OFF;
    end else if (link_ce) begin
      second_clock_pair <= next_clk_lvl;
      second_channel_data_pairs <= next_data_lvl;
      second_eighth_bit_pair <= next_eighth_lvl;
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  chk_clk_decode: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (link_ce && !pd_s && cfg_l[1:0] == `LSCPC_FLD_ACTIVE &&
     cfg_l[3:2] == `LSCPC_FLD_ZERO)
    |=> second_clock_pair == lscpc_pkg::LSCPC_LVL_ZERO
  ) else $error("clock pair not forced to zero");

  chk_clk_needs_data: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (second_clock_pair != lscpc_pkg::LSCPC_LVL_OFF
     |-> second_channel_data_pairs != lscpc_pkg::LSCPC_LVL_OFF) and
    (second_clock_pair == lscpc_pkg::LSCPC_LVL_ACT
     |-> second_channel_data_pairs == lscpc_pkg::LSCPC_LVL_ACT)
  ) else $error("clock pair above data pairs");

  chk_field_ceiling: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (second_channel_data_pairs == lscpc_pkg::LSCPC_LVL_ACT &&
     $past(link_ce))
    |-> ($past(cfg_l[1:0]) == `LSCPC_FLD_ACTIVE && !$past(pd_s))
  ) else $error("data pairs active without field or sequencer");

  chk_data_down: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (link_ce && cfg_l[1:0] == `LSCPC_FLD_DOWN)
    |=> (second_channel_data_pairs == lscpc_pkg::LSCPC_LVL_OFF &&
         second_clock_pair == lscpc_pkg::LSCPC_LVL_OFF &&
         second_eighth_bit_pair == lscpc_pkg::LSCPC_LVL_OFF)
  ) else $error("data field down did not power down channel");

  chk_clk_apart: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (link_ce && !pd_s && cfg_l[1:0] == `LSCPC_FLD_ACTIVE &&
     cfg_l[3:2] == `LSCPC_FLD_DOWN)
    |=> (second_clock_pair == lscpc_pkg::LSCPC_LVL_OFF &&
         second_channel_data_pairs == lscpc_pkg::LSCPC_LVL_ACT)
  ) else $error("clock pair not disabled apart from data");

  chk_seq_override: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (link_ce && pd_s) |=> (second_clock_pair == lscpc_pkg::LSCPC_LVL_OFF &&
      second_channel_data_pairs == lscpc_pkg::LSCPC_LVL_OFF &&
      second_eighth_bit_pair == lscpc_pkg::LSCPC_LVL_OFF)
  ) else $error("lines not down under sequencer power-down");

  chk_eighth_limit: assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (second_eighth_bit_pair == lscpc_pkg::LSCPC_LVL_ACT && $past(link_ce))
    |-> (second_channel_data_pairs == lscpc_pkg::LSCPC_LVL_ACT &&
         $past(cfg_l[5:4]) == `LSCPC_FLD_ACTIVE)
  ) else $error("eighth pair active without both fields");

  chk_presence_held: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ps_state == lscpc_pkg::LSCPC_PS_HOLD &&
     $past(ps_state) == lscpc_pkg::LSCPC_PS_HOLD) |-> $stable(presence)
  ) else $error("presence flag changed after capture");

  chk_presence_read: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (bus_done && read && hit &&
     $past(ps_state) == lscpc_pkg::LSCPC_PS_HOLD)
    |-> readdata[`LSCPC_PRESENT_BIT] == presence
  ) else $error("presence readback wrong");

  chk_reserved_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (bus_done && read) |-> (readdata[0] == 1'b0 && readdata[31:8] == 24'h0)
  ) else $error("reserved bits read nonzero");

endmodule

//--- verification/lscpc_panel_model.sv
// Purpose: flat panel seen on the second-channel pairs
// Assumes: levels one-hot: 001 off, 010 forced zero, 100 active
// Notes:   flags any pair running above the data pairs
module lscpc_panel_model (
  input wire logic attached,
  input lscpc_pkg::lscpc_level_t clock_pair,
  input lscpc_pkg::lscpc_level_t data_pairs,
  input lscpc_pkg::lscpc_level_t eighth_pair,
  output logic serial_data,
  output logic bad
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // boot strap and line checks
  // ---------------------------------------------------------------------
  // a present panel pulls the serial data line up; absent leaves it low
  assign serial_data = attached;
  // pairs capped by data
  // one-hot codes grow with activity, so a plain compare ranks them
  assign bad = (clock_pair > data_pairs) || (eighth_pair > data_pairs);
endmodule

//--- verification/lvds_second_channel_power_ctl_test.sv
// Purpose: register and line-state checks of the power control block
// Assumes: one bus wait cycle, link levels settle within 60 cycles
// Notes:   clk_en is held high throughout; its freeze is not covered
module lvds_second_channel_power_ctl_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  logic ref_clk, link_clk, rst_n, clk_en, read, write, seq_power_down;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, q;
  logic waitrequest, serial_data, attached, bad;
  lscpc_pkg::lscpc_level_t ck, dt, eb;
  logic [1:0] c, d, e;
  int mismatches, num_checks, cyc;

  // ---------------------------------------------------------------------
  // clocks: link clock phase offset keeps edges apart
  // ---------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end

  lscpc_top lscpc_top_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .link_clk(link_clk), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .seq_power_down(seq_power_down),
    .display_serial_bus_data(serial_data),
    .second_clock_pair(ck), .second_channel_data_pairs(dt),
    .second_eighth_bit_pair(eb)
  );

  lscpc_panel_model lscpc_panel_model_i (
    .attached(attached), .clock_pair(ck), .data_pairs(dt),
    .eighth_pair(eb), .serial_data(serial_data), .bad(bad)
  );

  // ---------------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------------
  task automatic conclude;
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      conclude;
    end
  end

  // ---------------------------------------------------------------------
  // bus access: hold the request until waitrequest is seen low
  // ---------------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    // an edge between transfers keeps one assignment per time step
    @(posedge ref_clk);
    address <= a;
    writedata <= wd;
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 50) chk("bus_answer", 32'h0, 32'h1);
  endtask

  // read the word at address a and compare it
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk("control_word", exp, q);
  endtask

  // ---------------------------------------------------------------------
  // expected levels worked out from the field codes
  // ---------------------------------------------------------------------
  function automatic lscpc_pkg::lscpc_level_t lv(input logic [1:0] f);
    case (f)
      2'h1: lv = lscpc_pkg::LSCPC_LVL_ZERO;
      2'h3: lv = lscpc_pkg::LSCPC_LVL_ACT;
      // reserved code is taken as powered down
      default: lv = lscpc_pkg::LSCPC_LVL_OFF;
    endcase
  endfunction

  function automatic lscpc_pkg::lscpc_level_t mn(
      input lscpc_pkg::lscpc_level_t a, input lscpc_pkg::lscpc_level_t b);
    mn = (a < b) ? a : b;
  endfunction

  // wait, bounded, for the link levels, then compare all three
  task automatic wait_lv(input lscpc_pkg::lscpc_level_t xc,
                         input lscpc_pkg::lscpc_level_t xd,
                         input lscpc_pkg::lscpc_level_t xe);
    int n;
    n = 0;
    while (n < 60 && !(ck === xc && dt === xd && eb === xe)) begin
      @(posedge ref_clk);
      n++;
    end
    chk("clock_pair", 32'(xc), 32'(ck));
    chk("data_pairs", 32'(xd), 32'(dt));
    chk("eighth_pair", 32'(xe), 32'(eb));
    chk("panel_limits", 32'h0, 32'(bad));
  endtask

  // reset long enough for the link domain, then presence capture
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    clk_en <= 1'b1;
    read <= 1'b0;
    write <= 1'b0;
    address <= 4'h0;
    byteenable <= 4'hF;
    writedata <= 32'h0;
    seq_power_down <= 1'b0;
    attached <= 1'b1;
    mismatches = 0;
    num_checks = 0;
    cyc = 0;
    do_reset;
    rd_chk(4'h0, 32'h00000002);
    wait_lv(lv(2'h0), lv(2'h0), lv(2'h0));
    // every pairing of data and clock codes; stray bits set on purpose
    for (int i = 0; i < 16; i++) begin
      d = i[1:0];
      c = i[3:2];
      e = d ^ c;
      xfer(1'b1, 4'h0, {24'hFFFFFF, e, c, d, 2'h3}, 4'hF);
      rd_chk(4'h0, {24'h0, e, c, d, 2'h2});
      wait_lv(mn(lv(c), lv(d)), lv(d), mn(lv(e), lv(d)));
      chk("data_code", 32'(lv(d)), 32'(dt));
      chk("clock_limit", 32'(mn(lv(c), lv(d))), 32'(ck));
      if (d == 2'h3) chk("clock_apart", 32'(lv(c)), 32'(ck));
      chk("eighth_limit", 32'(mn(lv(e), lv(d))), 32'(eb));
    end
    // sequencer power-down overrides fully active fields
    xfer(1'b1, 4'h0, 32'h000000FC, 4'hF);
    wait_lv(lv(2'h3), lv(2'h3), lv(2'h3));
    seq_power_down <= 1'b1;
    wait_lv(lv(2'h0), lv(2'h0), lv(2'h0));
    seq_power_down <= 1'b0;
    wait_lv(lv(2'h3), lv(2'h3), lv(2'h3));
    // byte lane 0 disabled: write has no effect
    xfer(1'b1, 4'h0, 32'h00000000, 4'hE);
    rd_chk(4'h0, 32'h000000FE);
    // unmapped word: reads zero, write lands nowhere
    xfer(1'b1, 4'h1, 32'hFFFFFFFF, 4'hF);
    rd_chk(4'h1, 32'h00000000);
    rd_chk(4'h0, 32'h000000FE);
    // pin changes after boot and a write of zero leave the flag alone
    attached <= 1'b0;
    repeat (10) @(posedge ref_clk);
    xfer(1'b1, 4'h0, 32'h000000FC, 4'hF);
    rd_chk(4'h0, 32'h000000FE);
    // second reset mid-run with no panel: flag and fields clear
    do_reset;
    rd_chk(4'h0, 32'h00000000);
    wait_lv(lv(2'h0), lv(2'h0), lv(2'h0));
    conclude;
  end
endmodule
